// [src/scpl_pin_defs.vh]
// register map, field positions and reset values of the serial pin logic block
`ifndef SCPL_PIN_DEFS_VH
`define SCPL_PIN_DEFS_VH
// byte offsets on the register bus
`define SCPL_CTRL_A 8'h00
`define SCPL_CTRL_B 8'h04
`define SCPL_STAT_A 8'h08
`define SCPL_STAT_B 8'h0C
`define SCPL_VECTOR 8'h10
`define SCPL_EXTFEAT 8'h14
`define SCPL_COMMAND 8'h18
// control register fields
`define SCPL_C_RTS 0
`define SCPL_C_DTR 1
`define SCPL_C_AUTO 2
`define SCPL_C_DTRREQ 3
`define SCPL_C_WREQ 4
`define SCPL_C_MODE_LO 5
`define SCPL_C_MODE_HI 6
`define SCPL_C_FAC_LO 7
`define SCPL_C_FAC_HI 8
`define SCPL_C_XTAL 9
`define SCPL_C_IE_CTS 10
`define SCPL_C_IE_DCD 11
`define SCPL_C_IE_SYNC 12
`define SCPL_C_PAT_LO 16
`define SCPL_C_PAT_HI 23
`define SCPL_CTRL_RESET 24'h000000
`define SCPL_CTRL_MASK 24'hFF1FFF
// receive modes
`define SCPL_MODE_ASYNC 2'h0
`define SCPL_MODE_EXTSYNC 2'h1
`define SCPL_MODE_INTSYNC 2'h2
`define SCPL_MODE_FRAMED 2'h3
// clock factors
`define SCPL_FAC_X1 2'h0
`define SCPL_FAC_X16 2'h1
`define SCPL_FAC_X32 2'h2
`define SCPL_FAC_X64 2'h3
`define SCPL_FLAG_PATTERN 8'h7E
// status register fields
`define SCPL_S_CTS 0
`define SCPL_S_DCD 1
`define SCPL_S_HUNT 2
`define SCPL_S_TXEN 3
`define SCPL_S_RXEN 4
`define SCPL_S_TXEMPTY 5
`define SCPL_S_CTS_CHG 6
`define SCPL_S_DCD_CHG 7
`define SCPL_S_SYNC_CHG 8
`define SCPL_S_ASSEMBLING 9
`define SCPL_S_BITS_LO 12
`define SCPL_S_BITS_HI 14
// extended feature and command fields
`define SCPL_X_READBACK 0
`define SCPL_X_RESET 8'h00
`define SCPL_CMD_END_SERVICE 0
`define SCPL_VECTOR_RESET 8'h00
// interrupt vector status codes, placed in vector bits 3..1
`define SCPL_VS_NONE 3'h3
`define SCPL_VS_CHAN_A 3'h5
`define SCPL_VS_CHAN_B 3'h1
`endif

// [src/scpl_pin_logic.v]
// pin-level logic of a dual-channel serial controller behind an AHB-Lite register port
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`include "scpl_pin_defs.vh"
`default_nettype none
module scpl_pin_logic (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // AHB-Lite register port
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // modem pins, bit 0 channel A, bit 1 channel B
    input wire [1:0] clearToSendN,
    input wire [1:0] carrier_detect_in,
    output reg [1:0] requestToSendN,
    output reg [1:0] dtrRequestN,
    // alignment pins, split into input, output and enable
    input wire [1:0] syncPinIn,
    output reg [1:0] syncPinOut,
    output reg [1:0] syncPinOeN,
    // receive clock and data pins
    input wire [1:0] rx_tx_clock_pin,
    input wire [1:0] rxDataPin,
    // wait / request pins
    output reg [1:0] waitReqOut,
    output reg [1:0] waitReqOeN,
    // protocol engine side, same clock domain
    input wire [1:0] txEmpty,
    input wire [1:0] dmaRequest,
    input wire [1:0] cpuWait,
    output reg [1:0] txEnable,
    output reg [1:0] rxEnable,
    // host bus strobes and selects
    input wire acknowledge_cycle_n,
    input wire readStrobeN,
    input wire data_strobe_n,
    input wire channelSelB,
    input wire dataCmdSel,
    // vector drive onto the host data bus
    output reg [7:0] vectorOut,
    output reg vectorOeN,
    // daisy chain and service request
    input wire priority_enable_in,
    output reg priority_enable_out,
    output reg serviceReqOut,
    output reg serviceReqOeN
);
    localparam NCH = 2;

    // bus capture
    reg wrPend_reg;
    reg [7:0] wrAddr_reg;
    reg [7:0] vectorBase_reg;
    reg [7:0] extFeat_reg;
    reg underService_reg;
    wire addrPhase = hsel && hready && htrans[1];
    wire wrStrobe = wrPend_reg;
    wire [23:0] ctrlBus [0:NCH-1];
    wire [15:0] statBus [0:NCH-1];
    wire [NCH-1:0] pending;

    // host-side pins come from another clock domain: two flops before use
    reg [1:0] ackS;
    reg [1:0] rdS;
    reg [1:0] dsS;
    reg [1:0] chS;
    reg [1:0] dcS;
    reg [1:0] ieiS;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ackS <= 2'h3;
            rdS <= 2'h3;
            dsS <= 2'h3;
            chS <= 2'h0;
            dcS <= 2'h0;
            ieiS <= 2'h0;
        end else begin
            ackS <= {ackS[0], acknowledge_cycle_n};
            rdS <= {rdS[0], readStrobeN};
            dsS <= {dsS[0], data_strobe_n};
            chS <= {chS[0], channelSelB};
            dcS <= {dcS[0], dataCmdSel};
            ieiS <= {ieiS[0], priority_enable_in};
        end
    end

    // write data phase follows the captured address phase; zero wait states
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wrPend_reg <= addrPhase && hwrite;
            if (addrPhase) begin
                wrAddr_reg <= haddr;
            end
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // read data is latched at the address edge so it stands for the data phase
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h00000000;
        end else if (addrPhase && !hwrite) begin
            case (haddr)
                // control readback is an extended feature, zero until enabled
                `SCPL_CTRL_A: hrdata <= extFeat_reg[`SCPL_X_READBACK] ?
                    {8'h00, ctrlBus[0]} : 32'h00000000;
                `SCPL_CTRL_B: hrdata <= extFeat_reg[`SCPL_X_READBACK] ?
                    {8'h00, ctrlBus[1]} : 32'h00000000;
                `SCPL_STAT_A: hrdata <= {16'h0000, statBus[0]};
                `SCPL_STAT_B: hrdata <= {16'h0000, statBus[1]};
                `SCPL_VECTOR: hrdata <= {24'h000000, vectorBase_reg};
                `SCPL_EXTFEAT: hrdata <= {24'h000000, extFeat_reg};
                `SCPL_COMMAND: hrdata <= {31'h00000000, underService_reg};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    // shared registers; extended features reset to off
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vectorBase_reg <= `SCPL_VECTOR_RESET;
            extFeat_reg <= `SCPL_X_RESET;
        end else if (wrStrobe) begin
            if (wrAddr_reg == `SCPL_VECTOR) begin
                vectorBase_reg <= hwdata[7:0];
            end
            if (wrAddr_reg == `SCPL_EXTFEAT) begin
                extFeat_reg <= hwdata[7:0];
            end
        end
    end

    // interrupt acknowledge: vector status code from highest pending channel
    wire anyPending = |pending;
    wire ackActive = !ackS[1];
    wire strobeActive = !rdS[1] || !dsS[1];
    wire [2:0] vecStatus = pending[0] ? `SCPL_VS_CHAN_A :
        (pending[1] ? `SCPL_VS_CHAN_B : `SCPL_VS_NONE);
    // only the top requester with enable-in high answers the acknowledge
    wire vecGo = ackActive && strobeActive && ieiS[1] && anyPending;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vectorOut <= 8'h00;
            vectorOeN <= 1'b1;
            underService_reg <= 1'b0;
        end else begin
            vectorOeN <= !vecGo;
            if (vecGo) begin
                // channel B read carries status, channel A never does
                vectorOut <= chS[1] ? {vectorBase_reg[7:4], vecStatus, vectorBase_reg[0]} :
                    vectorBase_reg;
            end
            if (vecGo && !underService_reg) begin
                underService_reg <= 1'b1;
            end else if (wrStrobe && wrAddr_reg == `SCPL_COMMAND &&
                    hwdata[`SCPL_CMD_END_SERVICE]) begin
                underService_reg <= 1'b0;
            end
        end
    end

    // daisy chain out and open-drain service request, one flop each
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            priority_enable_out <= 1'b0;
            serviceReqOut <= 1'b0;
            serviceReqOeN <= 1'b1;
        end else begin
            priority_enable_out <= ieiS[1] && !underService_reg &&
                !(ackActive && anyPending);
            serviceReqOut <= 1'b0;
            // pulled low only while pending and not yet taken into service
            serviceReqOeN <= !(anyPending && !underService_reg);
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch = ch + 1) begin : gChan
            reg [23:0] ctrl_reg;
            reg [2:0] ctsS;
            reg [2:0] dcdS;
            reg [2:0] synS;
            reg [2:0] clkS;
            reg [2:0] rxdS;
            reg rtsHold_reg;
            reg [2:0] chg_reg;
            reg [5:0] edgeCnt_reg;
            reg [7:0] shift_reg;
            reg [2:0] bitCnt_reg;
            reg assembling_reg;
            reg syncActive_reg;
            wire [1:0] mode = ctrl_reg[`SCPL_C_MODE_HI:`SCPL_C_MODE_LO];
            wire [1:0] fac = ctrl_reg[`SCPL_C_FAC_HI:`SCPL_C_FAC_LO];
            wire autoEn = ctrl_reg[`SCPL_C_AUTO];
            wire isAsync = mode == `SCPL_MODE_ASYNC;
            wire syncIsOutput = !ctrl_reg[`SCPL_C_XTAL] &&
                (mode == `SCPL_MODE_INTSYNC || mode == `SCPL_MODE_FRAMED);
            wire clkRise = clkS[1] && !clkS[2];
            wire ctsEdge = ctsS[1] ^ ctsS[2];
            wire dcdEdge = dcdS[1] ^ dcdS[2];
            wire synEdge = synS[1] ^ synS[2];
            wire synFall = !synS[1] && synS[2];
            wire [5:0] facLast = (fac == `SCPL_FAC_X16) ? 6'h0F :
                ((fac == `SCPL_FAC_X32) ? 6'h1F : 6'h3F);
            wire [5:0] facMid = {1'b0, facLast[5:1]};
            wire sampleTick = clkRise && ((fac == `SCPL_FAC_X1) || edgeCnt_reg == facMid);
            wire [7:0] pattern = (mode == `SCPL_MODE_FRAMED) ? `SCPL_FLAG_PATTERN :
                ctrl_reg[`SCPL_C_PAT_HI:`SCPL_C_PAT_LO];
            wire [7:0] nextShift = {shift_reg[6:0], rxdS[1]};
            wire match = sampleTick && syncIsOutput && nextShift == pattern;
            wire [2:0] clrBits = (wrStrobe && wrAddr_reg == (ch ? `SCPL_STAT_B :
                `SCPL_STAT_A)) ? hwdata[`SCPL_S_SYNC_CHG:`SCPL_S_CTS_CHG] : 3'h0;
            wire [2:0] setBits = {synEdge && isAsync && !ctrl_reg[`SCPL_C_XTAL],
                dcdEdge, ctsEdge};

            // pin synchronisers; stage 1 feeds stage 2 only, stage 3 finds edges
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ctsS <= 3'h7;
                    dcdS <= 3'h7;
                    synS <= 3'h7;
                    clkS <= 3'h0;
                    rxdS <= 3'h7;
                end else begin
                    ctsS <= {ctsS[1:0], clearToSendN[ch]};
                    dcdS <= {dcdS[1:0], carrier_detect_in[ch]};
                    synS <= {synS[1:0], syncPinIn[ch]};
                    clkS <= {clkS[1:0], rx_tx_clock_pin[ch]};
                    rxdS <= {rxdS[1:0], rxDataPin[ch]};
                end
            end

            // control register; wait/request resets to the wait function
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_reg <= `SCPL_CTRL_RESET;
                end else if (wrStrobe && wrAddr_reg == (ch ? `SCPL_CTRL_B : `SCPL_CTRL_A)) begin
                    ctrl_reg <= hwdata[23:0] & `SCPL_CTRL_MASK;
                end
            end

            // change flags: a new edge wins over a software clear in the same cycle
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    chg_reg <= 3'h0;
                end else begin
                    chg_reg <= (chg_reg & ~clrBits) | setBits;
                end
            end

            // request-to-send: async auto-enable holds the pin until the transmitter empties
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    rtsHold_reg <= 1'b0;
                end else if (ctrl_reg[`SCPL_C_RTS]) begin
                    rtsHold_reg <= 1'b1;
                end else if (isAsync && autoEn) begin
                    rtsHold_reg <= rtsHold_reg && !txEmpty[ch];
                end else begin
                    rtsHold_reg <= 1'b0;
                end
            end

            // receive sampler: count clock edges per bit, realign on data transitions
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    edgeCnt_reg <= 6'h00;
                    shift_reg <= 8'h00;
                end else begin
                    if (rxdS[1] ^ rxdS[2]) begin
                        edgeCnt_reg <= 6'h00;
                    end else if (clkRise) begin
                        edgeCnt_reg <= (edgeCnt_reg == facLast) ? 6'h00 :
                            edgeCnt_reg + 6'h01;
                    end
                    if (sampleTick) begin
                        shift_reg <= nextShift;
                    end
                end
            end

            // character assembly; external sync counts from the edge before the fall
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    bitCnt_reg <= 3'h0;
                    assembling_reg <= 1'b0;
                end else if (mode == `SCPL_MODE_EXTSYNC && synFall && !assembling_reg) begin
                    // one bit already taken at the preceding receive edge
                    bitCnt_reg <= sampleTick ? 3'h2 : 3'h1;
                    assembling_reg <= 1'b1;
                end else if (mode != `SCPL_MODE_EXTSYNC) begin
                    bitCnt_reg <= sampleTick ? bitCnt_reg + 3'h1 : bitCnt_reg;
                    assembling_reg <= 1'b0;
                end else if (sampleTick && assembling_reg) begin
                    bitCnt_reg <= bitCnt_reg + 3'h1;
                end
            end

            // alignment output: active for the receive clock cycle of a match, not latched
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    syncActive_reg <= 1'b0;
                end else if (match) begin
                    syncActive_reg <= 1'b1;
                end else if (clkRise) begin
                    syncActive_reg <= 1'b0;
                end
            end

            // pin and enable outputs, each from a flop
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    requestToSendN[ch] <= 1'b1;
                    dtrRequestN[ch] <= 1'b1;
                    syncPinOut[ch] <= 1'b1;
                    syncPinOeN[ch] <= 1'b1;
                    waitReqOut[ch] <= 1'b0;
                    waitReqOeN[ch] <= 1'b1;
                    txEnable[ch] <= 1'b0;
                    rxEnable[ch] <= 1'b0;
                end else begin
                    requestToSendN[ch] <= !rtsHold_reg;
                    dtrRequestN[ch] <= ctrl_reg[`SCPL_C_DTRREQ] ? !dmaRequest[ch] :
                        !ctrl_reg[`SCPL_C_DTR];
                    syncPinOut[ch] <= !syncActive_reg;
                    syncPinOeN[ch] <= !syncIsOutput;
                    if (ctrl_reg[`SCPL_C_WREQ]) begin
                        waitReqOut[ch] <= !dmaRequest[ch];
                        waitReqOeN[ch] <= 1'b0;
                    end else begin
                        // open drain: only ever pulls low
                        waitReqOut[ch] <= 1'b0;
                        waitReqOeN[ch] <= !cpuWait[ch];
                    end
                    txEnable[ch] <= autoEn ? !ctsS[1] : 1'b1;
                    rxEnable[ch] <= autoEn ? !dcdS[1] : 1'b1;
                end
            end

            assign ctrlBus[ch] = ctrl_reg;
            // hunt bit is the inverted alignment input level, in every mode
            assign statBus[ch] = {1'b0, bitCnt_reg, 2'h0, assembling_reg, chg_reg,
                txEmpty[ch], rxEnable[ch], txEnable[ch], !synS[1], dcdS[1], ctsS[1]};
            assign pending[ch] = |(chg_reg &
                ctrl_reg[`SCPL_C_IE_SYNC:`SCPL_C_IE_CTS]);
        end
    endgenerate
endmodule
`default_nettype wire

// [src/scpl_pin_logic_end.v]
// intentionally minimal: no further design content
`default_nettype none
`default_nettype wire

// [sim/scpl_pin_props.sv]
// assertion checker on the serial pin logic ports
`default_nettype none
module scpl_pin_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // host strobes and daisy chain
    input wire logic acknowledge_cycle_n,
    input wire logic readStrobeN,
    input wire logic data_strobe_n,
    input wire logic priority_enable_in,
    input wire logic priority_enable_out,
    input wire logic vectorOeN,
    input wire logic serviceReqOut,
    input wire logic serviceReqOeN,
    // two-way pins
    input wire logic [1:0] waitReqOut,
    input wire logic [1:0] waitReqOeN,
    input wire logic [1:0] syncPinOut,
    input wire logic [1:0] syncPinOeN
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // five cycles outlast the two synchroniser flops plus the output register
    chain_block_a: assert property (!priority_enable_in [*5] |=> !priority_enable_out)
        else $error("enable-out high with enable-in low");
    chain_ack_a: assert property (!vectorOeN |-> !priority_enable_out)
        else $error("enable-out high while vector driven");
    vec_gate_a: assert property (!priority_enable_in [*5] |=> vectorOeN)
        else $error("vector driven with enable-in low");
    vec_ack_a: assert property (acknowledge_cycle_n [*5] |=> vectorOeN)
        else $error("vector driven outside acknowledge");
    vec_strobe_a: assert property ((readStrobeN && data_strobe_n) [*5] |=> vectorOeN)
        else $error("vector driven without strobe");
    int_drain_a: assert property (!serviceReqOut)
        else $error("service request driven high");
    int_release_a: assert property ($fell(vectorOeN) |=> serviceReqOeN)
        else $error("service request not released in service");
    wait_drain_a: assert property ((waitReqOut & waitReqOeN) == 2'b00)
        else $error("wait pin high while not driven");
    sync_drive_a: assert property ((~syncPinOut & syncPinOeN) == 2'b00)
        else $error("alignment pulse while not driven");
endmodule
bind scpl_pin_logic scpl_pin_props chk (.core_clk(core_clk), .rst_n(rst_n),
    .acknowledge_cycle_n(acknowledge_cycle_n), .readStrobeN(readStrobeN),
    .data_strobe_n(data_strobe_n), .priority_enable_in(priority_enable_in),
    .priority_enable_out(priority_enable_out), .vectorOeN(vectorOeN),
    .serviceReqOut(serviceReqOut), .serviceReqOeN(serviceReqOeN), .waitReqOut(waitReqOut),
    .waitReqOeN(waitReqOeN), .syncPinOut(syncPinOut), .syncPinOeN(syncPinOeN));
`default_nettype wire

// [sim/scpl_host_model.sv]
// host side model: acknowledge cycles, selects and the neighbour above in the chain
`default_nettype none
module scpl_host_model (
    // clock
    input wire logic core_clk,
    // strobes idle high and selects low at start
    output logic acknowledge_cycle_n = 1'b1,
    output logic readStrobeN = 1'b1,
    output logic data_strobe_n = 1'b1,
    output logic channelSelB = 1'b0,
    output logic dataCmdSel = 1'b0,
    // daisy chain from the device above
    output wire logic priority_enable_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic higherBusy = 1'b1;
    // the device above passes the chain only while it is idle
    assign priority_enable_in = !higherBusy;
    // open an acknowledge cycle, strobing with read or data strobe
    task automatic ackOpen(input logic chanB, input logic useDs);
        @(posedge core_clk);
        channelSelB <= chanB;
        dataCmdSel <= 1'b1;
        acknowledge_cycle_n <= 1'b0;
        readStrobeN <= useDs;
        data_strobe_n <= !useDs;
    endtask
    // strobes go back up together so no partial cycle is seen
    task automatic ackClose();
        @(posedge core_clk);
        acknowledge_cycle_n <= 1'b1;
        readStrobeN <= 1'b1;
        data_strobe_n <= 1'b1;
        dataCmdSel <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [sim/scpl_pin_logic_tb.sv]
// self-checking testbench of the serial pin logic block
`include "scpl_pin_defs.vh"
`default_nettype none
module scpl_pin_logic_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    logic [1:0] cts = 2'h0, dcd = 2'h0, syncDrv = 2'h3, rxClk = 2'h0, rxData = 2'h0;
    logic [1:0] txEmpty = 2'h0, dmaReq = 2'h0, cpuWait = 2'h0;
    logic prevSync = 1'b1;
    wire logic hreadyout, hresp, ackN, rdN, dsN, chB, dcSel, ein, eout, srOut, srOeN, vecOeN;
    wire logic [1:0] rtsN, dtrN, syncOut, syncOeN, syncLine, wrOut, wrOeN, txEn, rxEn;
    wire logic [7:0] vecOut;
    wire logic [31:0] hrdata;
    int mismatches = 0, n_checks = 0, pulses = 0;
    // the alignment wire is ours while the block leaves it undriven
    assign syncLine = (syncOeN & syncDrv) | (~syncOeN & syncOut);
    always #5 core_clk = ~core_clk;
    scpl_pin_logic DUT (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .clearToSendN(cts),
        .carrier_detect_in(dcd), .requestToSendN(rtsN), .dtrRequestN(dtrN),
        .syncPinIn(syncLine), .syncPinOut(syncOut), .syncPinOeN(syncOeN),
        .rx_tx_clock_pin(rxClk), .rxDataPin(rxData), .waitReqOut(wrOut), .waitReqOeN(wrOeN),
        .txEmpty(txEmpty), .dmaRequest(dmaReq), .cpuWait(cpuWait), .txEnable(txEn),
        .rxEnable(rxEn), .acknowledge_cycle_n(ackN), .readStrobeN(rdN), .data_strobe_n(dsN),
        .channelSelB(chB), .dataCmdSel(dcSel), .vectorOut(vecOut), .vectorOeN(vecOeN),
        .priority_enable_in(ein), .priority_enable_out(eout), .serviceReqOut(srOut),
        .serviceReqOeN(srOeN));
    scpl_host_model host (.core_clk(core_clk), .acknowledge_cycle_n(ackN), .readStrobeN(rdN),
        .data_strobe_n(dsN), .channelSelB(chB), .dataCmdSel(dcSel), .priority_enable_in(ein));
    // count falling alignment pulses on channel B
    always @(posedge core_clk) begin
        prevSync <= syncOut[1];
        if (prevSync === 1'b1 && syncOut[1] === 1'b0) pulses++;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one single transfer; the wait has no bound of its own, the watchdog cuts a hang
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
        xfer(1'b0, a, 32'h0);
        chk(nm, rd & m, e);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // msb first, link clock stands low between bytes
    task automatic sendByte(input int ch, input logic [7:0] v, input int n = 1);
        for (int i = 7; i >= 0; i--) begin
            rxData[ch] <= v[i];
            repeat (n) begin
                wt(4);
                rxClk[ch] <= 1'b1;
                wt(4);
                rxClk[ch] <= 1'b0;
            end
        end
    endtask
    // watchdog, far beyond the few thousand cycles the sequence needs
    initial begin
        #200us;
        mismatches++;
        complete_run();
    end
    initial begin
        wt(12);
        rst_n <= 1'b1;
        wt(4);
        chk("idlePins", 32'({hresp, rtsN, wrOeN, wrOut, txEn}), 32'hF3);
        rdChk("extfeat", `SCPL_EXTFEAT, 32'hFFFFFFFF, 32'h0);
        xfer(1'b1, `SCPL_CTRL_A, 32'hC00);
        rdChk("noReadback", `SCPL_CTRL_A, 32'hFFFFFFFF, 32'h0);
        xfer(1'b1, `SCPL_EXTFEAT, 32'h1);
        rdChk("readback", `SCPL_CTRL_A, 32'hFFFFFFFF, 32'hC00);
        rdChk("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h0);
        xfer(1'b1, `SCPL_VECTOR, 32'hC3);
        xfer(1'b1, `SCPL_STAT_A, 32'h1C0);
        // both edges of both modem inputs must flag and request service
        for (int k = 0; k < 2; k++) begin
            cts[0] <= !cts[0];
            dcd[0] <= !dcd[0];
            wt(6);
            rdChk("chgFlags", `SCPL_STAT_A, 32'hC0, 32'hC0);
            chk("intReq", 32'(srOeN), 32'h0);
            if (k == 0) xfer(1'b1, `SCPL_STAT_A, 32'h1C0);
        end
        host.ackOpen(1'b1, 1'b0);
        wt(6);
        chk("vecBlocked", 32'(vecOeN), 32'h1);
        host.higherBusy <= 1'b0;
        wt(6);
        chk("vecB", 32'({vecOeN, eout, vecOut}), 32'h0CB);
        host.ackClose();
        xfer(1'b1, `SCPL_COMMAND, 32'h1);
        host.ackOpen(1'b0, 1'b1);
        wt(6);
        chk("vecA", 32'({vecOeN, vecOut}), 32'h0C3);
        host.ackClose();
        xfer(1'b1, `SCPL_COMMAND, 32'h1);
        xfer(1'b1, `SCPL_STAT_A, 32'h1C0);
        wt(6);
        chk("chainIdle", 32'({eout, srOeN}), 32'h3);
        // enables follow the modem inputs only under auto-enable
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, `SCPL_CTRL_A, k[1] ? 32'h4 : 32'h0);
            cts[0] <= k[0];
            dcd[0] <= k[0];
            wt(6);
            chk("autoEn", 32'({txEn[0], rxEn[0]}), (k == 3) ? 32'h0 : 32'h3);
        end
        cts[0] <= 1'b0;
        xfer(1'b1, `SCPL_CTRL_A, 32'h5);
        wt(5);
        chk("rtsOn", 32'(rtsN[0]), 32'h0);
        xfer(1'b1, `SCPL_CTRL_A, 32'h4);
        wt(8);
        chk("rtsHold", 32'(rtsN[0]), 32'h0);
        txEmpty[0] <= 1'b1;
        wt(4);
        chk("rtsOff", 32'(rtsN[0]), 32'h1);
        txEmpty[0] <= 1'b0;
        xfer(1'b1, `SCPL_CTRL_A, 32'h25);
        xfer(1'b1, `SCPL_CTRL_A, 32'h24);
        wt(5);
        chk("rtsSync", 32'(rtsN[0]), 32'h1);
        xfer(1'b1, `SCPL_CTRL_B, 32'h2);
        wt(5);
        chk("dtr", 32'(dtrN[1]), 32'h0);
        cpuWait[0] <= 1'b1;
        xfer(1'b1, `SCPL_CTRL_B, 32'h1A);
        for (int k = 0; k < 2; k++) begin
            dmaReq[1] <= k[0];
            wt(4);
            chk("dmaReq", 32'({dtrN[1], wrOeN, wrOut}), k ? 32'h0 : 32'h12);
        end
        xfer(1'b1, `SCPL_CTRL_A, 32'h0);
        xfer(1'b1, `SCPL_STAT_A, 32'h1C0);
        // async alignment input moves the hunt status and sets the sync change flag
        for (int k = 0; k < 2; k++) begin
            syncDrv[0] <= k[0];
            wt(5);
            rdChk("hunt", `SCPL_STAT_A, 32'h104, k ? 32'h100 : 32'h104);
            chk("syncIn", 32'({syncOeN[0], txEn[0]}), 32'h3);
            xfer(1'b1, `SCPL_STAT_A, 32'h1C0);
        end
        // one pattern inside quiet bytes gives exactly one pulse
        for (int k = 0; k < 3; k++) begin
            xfer(1'b1, `SCPL_CTRL_B, k ? (k[1] ? 32'hE0 : 32'h60) : 32'hA50040);
            pulses = 0;
            sendByte(1, 8'h00, k[1] ? 16 : 1);
            sendByte(1, k ? `SCPL_FLAG_PATTERN : 8'hA5, k[1] ? 16 : 1);
            sendByte(1, 8'h00, k[1] ? 16 : 1);
            chk("syncPulse", 32'({syncOeN[1], 4'(pulses)}), 32'h1);
        end
        // external sync: input held low past the sync byte
        xfer(1'b1, `SCPL_CTRL_B, 32'h20);
        syncDrv[1] <= 1'b0;
        sendByte(1, 8'h00);
        syncDrv[1] <= 1'b1;
        rdChk("extSync", `SCPL_STAT_B, 32'h7200, 32'h1200);
        complete_run();
    end
endmodule
`default_nettype wire
